// file: hdl/wdr_pkg.sv
package wdr_pkg;

	// Register indices as printed, byte address is four times the index
	localparam logic [7:0]  KEY_IDX        = 8'ha6;
	localparam logic [7:0]  AUX_IDX        = 8'h8e;
	localparam logic [7:0]  STAT_IDX       = 8'hc0;
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] KEY_ADDR       = {2'b00, KEY_IDX, 2'b00};
	localparam logic [11:0] AUX_ADDR       = {2'b00, AUX_IDX, 2'b00};
	localparam logic [11:0] STAT_ADDR      = {2'b00, STAT_IDX, 2'b00};

	// Service key values
	localparam logic [7:0]  KEY_FIRST      = 8'h1e;
	localparam logic [7:0]  KEY_SECOND     = 8'he1;

	// Auxiliary control layout
	localparam int          AUX_HOLD_BIT   = 4;
	localparam logic [7:0]  AUX_RST        = 8'h00;

	// Counter
	localparam int          CNT_WIDTH      = 14;
	localparam logic [13:0] CNT_MAX        = 14'h3fff;

	// Reset-out pulse timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          OSC_PERIOD_NS  = 10;
	localparam int          RST_PULSE_OSCILLATOR_PERIOD = 98;
	localparam int          RST_PULSE_CYC  = (RST_PULSE_OSCILLATOR_PERIOD * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Power state of the oscillator domain
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_DOWN,
		PWR_WAKE_HOLD
	} wdr_pwr_e;

	// Status register view
	typedef struct packed {
		logic [23:0] zero;
		logic        rst_pin_level;
		logic        idle_active;
		logic        wake_hold;
		logic        power_down;
		logic        pulse_active;
		logic        key_armed;
		logic        enabled;
		logic        reserved0;
	} wdr_status_s;

endpackage

// file: hdl/wdr_watchdog.sv
// Function
// - Starts disabled; 1E then E1 enables
// - Enabled counter increments every machine cycle
// - Only reset or overflow disables it
// - Reaching 3FFF overflows and resets device
// - Key pair restarts count from zero
// - Key write-only; counter unreadable, unwritable
// - Overflow drives 98-period high pin pulse
// - Power-down freezes counter
// - Power-down exits on reset or enabled interrupt
// - After wake, hold while interrupt pin low
// - Hold bit clear: counts during idle
// - Hold bit set: freeze during idle
// - Idle ends on interrupt; registers kept
// - Hold bit is aux bit 4, resets zero
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module wdr_watchdog
	import wdr_pkg::*;
#(
	parameter int CNT_W     = CNT_WIDTH,
	parameter int PULSE_CYC = RST_PULSE_CYC
) (
	input  wire logic                clock,
	input  wire logic                rstn,
	input  wire logic                clk_en,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                mach_cycle_stb,
	input  wire logic                idle_enter,
	input  wire logic                pdown_enter,
	input  wire logic                irq_pending,
	input  wire logic [1:0]          ext_wake_en,
	input  wire logic                ext_wake_irq_zero_n,
	input  wire logic                ext_wake_irq_one_n,
	input  wire logic                rst_pin_i,
	output logic                     rst_pin_o,
	output logic                     rst_pin_oe,
	output logic                     device_reset,
	output logic                     idle_active,
	output logic                     osc_stopped
);

	// Elaboration check
	if (CNT_W != CNT_WIDTH || PULSE_CYC < 1 || PULSE_CYC > 65535) begin : g_bad_param
		$error("wdr_watchdog: unsupported parameter value");
	end

	logic [CNT_W-1:0] cnt_r;
	logic [15:0]      pulse_cnt_r;
	logic             enabled_r;
	logic             key_armed_r;
	logic             idle_r;
	logic [7:0]       aux_r;
	logic [31:0]      prdata_r;
	logic             slverr_r;
	wdr_pwr_e         pwr_r;
	wdr_pwr_e         pwr_nxt;
	wdr_status_s      status;
	logic             setup_ph;
	logic             wr_acc;
	logic             key_wr;
	logic             aux_wr;
	logic             service;
	logic             wake_low;
	logic             wake_req;
	logic             hold_idle;
	logic             count_en;
	logic             overflow;
	logic             pulse_on;

	// Bus phases and decode
	assign setup_ph = psel & ~penable;
	assign wr_acc   = clk_en & psel & penable & pwrite;
	assign key_wr   = wr_acc & (paddr == KEY_ADDR) & pstrb[0];
	assign aux_wr   = wr_acc & (paddr == AUX_ADDR) & pstrb[0];
	assign pready   = penable & clk_en;
	assign prdata   = prdata_r;
	assign pslverr  = penable & slverr_r;

	// Key pair completed
	assign service  = key_wr & key_armed_r & (pwdata[7:0] == KEY_SECOND);

	// Wake sources are level, active low, and must be enabled
	assign wake_low = (ext_wake_en[0] & ~ext_wake_irq_zero_n) | (ext_wake_en[1] & ~ext_wake_irq_one_n);
	assign wake_req = wake_low;

	// Counter gating
	assign hold_idle = idle_r & aux_r[AUX_HOLD_BIT];
	assign count_en  = clk_en & enabled_r & mach_cycle_stb & (pwr_r == PWR_RUN) & ~hold_idle & ~service;
	assign overflow  = count_en & (cnt_r == CNT_MAX - 14'h0001);
	assign pulse_on  = (pulse_cnt_r != 16'h0000);

	// Outputs
	assign rst_pin_o    = pulse_on;
	assign rst_pin_oe   = pulse_on;
	assign device_reset = pulse_on;
	assign idle_active  = idle_r;
	assign osc_stopped  = (pwr_r != PWR_RUN);

	// Status view
	always_comb begin
		status               = '0;
		status.enabled       = enabled_r;
		status.key_armed     = key_armed_r;
		status.pulse_active  = pulse_on;
		status.power_down    = (pwr_r == PWR_DOWN);
		status.wake_hold     = (pwr_r == PWR_WAKE_HOLD);
		status.idle_active   = idle_r;
		status.rst_pin_level = rst_pin_i;
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else if (clk_en && setup_ph) begin
			slverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000; // Key reads back zero
			unique case (paddr)
				KEY_ADDR:  prdata_r <= 32'h0000_0000;
				AUX_ADDR:  prdata_r <= {24'h00_0000, aux_r};
				STAT_ADDR: prdata_r <= status;
				default:   slverr_r <= 1'b1;
			endcase
		end
	end

	// Key sequence tracker
	always_ff @(posedge clock) begin
		if (!rstn) begin
			key_armed_r <= 1'b0;
		end else if (clk_en) begin
			if (pulse_on || overflow) begin
				key_armed_r <= 1'b0;
			end else if (key_wr) begin
				key_armed_r <= (pwdata[7:0] == KEY_FIRST);
			end
		end
	end

	// Enable, one-way until reset or overflow
	always_ff @(posedge clock) begin
		if (!rstn) begin
			enabled_r <= 1'b0;
		end else if (clk_en) begin
			if (overflow) begin
				enabled_r <= 1'b0;
			end else if (service) begin
				enabled_r <= 1'b1;
			end
		end
	end

	// Watchdog counter
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (clk_en) begin
			if (service || overflow) begin
				cnt_r <= '0;
			end else if (count_en) begin
				cnt_r <= cnt_r + CNT_W'(1);
			end
		end
	end

	// Reset-out pulse timer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pulse_cnt_r <= 16'h0000;
		end else if (clk_en) begin
			if (overflow) begin
				pulse_cnt_r <= 16'(PULSE_CYC);
			end else if (pulse_on) begin
				pulse_cnt_r <= pulse_cnt_r - 16'h0001;
			end
		end
	end

	// Auxiliary control, hold bit only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			aux_r <= AUX_RST;
		end else if (clk_en) begin
			if (overflow) begin
				aux_r <= AUX_RST;
			end else if (aux_wr) begin
				aux_r[AUX_HOLD_BIT] <= pwdata[AUX_HOLD_BIT];
			end
		end
	end

	// Idle mode tracking
	always_ff @(posedge clock) begin
		if (!rstn) begin
			idle_r <= 1'b0;
		end else if (clk_en) begin
			if (irq_pending || overflow) begin
				idle_r <= 1'b0;
			end else if (idle_enter && pwr_r == PWR_RUN) begin
				idle_r <= 1'b1;
			end
		end
	end

	// Power state next value
	always_comb begin
		pwr_nxt = pwr_r;
		unique case (pwr_r)
			PWR_RUN: begin
				if (pdown_enter && !overflow) begin
					pwr_nxt = PWR_DOWN;
				end
			end
			PWR_DOWN: begin
				if (wake_req) begin
					pwr_nxt = PWR_WAKE_HOLD;
				end
			end
			PWR_WAKE_HOLD: begin
				if (!wake_low) begin
					pwr_nxt = PWR_RUN;
				end
			end
		endcase
	end

	// Power state register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pwr_r <= PWR_RUN;
		end else if (clk_en) begin
			pwr_r <= pwr_nxt;
		end
	end

	// Helper: cycles since the pulse started
	logic [15:0] pulse_age_r;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pulse_age_r <= 16'h0000;
		end else if (clk_en) begin
			if (overflow) begin
				pulse_age_r <= 16'h0000;
			end else if (pulse_on) begin
				pulse_age_r <= pulse_age_r + 16'h0001;
			end
		end
	end

	// Checks
	property p_start_disabled;
		@(posedge clock) $rose(rstn) |-> !enabled_r && !osc_stopped;
	endproperty
	a_start_disabled: assert property (p_start_disabled) else $error("enabled after reset");

	property p_key_enables;
		@(posedge clock) disable iff (!rstn)
		key_wr && key_armed_r && pwdata[7:0] == KEY_SECOND |=> enabled_r && cnt_r == '0;
	endproperty
	a_key_enables: assert property (p_key_enables) else $error("key pair did not enable");

	property p_key_arms;
		@(posedge clock) disable iff (!rstn)
		key_wr && pwdata[7:0] == KEY_FIRST && !pulse_on && !overflow |=> key_armed_r;
	endproperty
	a_key_arms: assert property (p_key_arms) else $error("first key byte did not arm");

	property p_counts;
		@(posedge clock) disable iff (!rstn)
		count_en && !overflow |=> cnt_r == $past(cnt_r) + CNT_W'(1);
	endproperty
	a_counts: assert property (p_counts) else $error("counter did not advance");

	property p_no_disable;
		@(posedge clock) disable iff (!rstn)
		enabled_r && !overflow |=> enabled_r;
	endproperty
	a_no_disable: assert property (p_no_disable) else $error("disabled without overflow");

	property p_overflow_pulse;
		@(posedge clock) disable iff (!rstn)
		overflow |=> device_reset && rst_pin_oe && !enabled_r && cnt_r == '0;
	endproperty
	a_overflow_pulse: assert property (p_overflow_pulse) else $error("overflow did not start reset");

	property p_key_readback;
		@(posedge clock) disable iff (!rstn)
		clk_en && setup_ph && paddr == KEY_ADDR |=> prdata == 32'h0000_0000;
	endproperty
	a_key_readback: assert property (p_key_readback) else $error("key register readable");

	property p_pulse_len;
		@(posedge clock) disable iff (!rstn)
		$fell(rst_pin_o) |-> pulse_age_r == 16'(PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

	property p_pdown_frozen;
		@(posedge clock) disable iff (!rstn)
		osc_stopped && !service |=> $stable(cnt_r);
	endproperty
	a_pdown_frozen: assert property (p_pdown_frozen) else $error("counter moved while stopped");

	property p_wake_hold;
		@(posedge clock) disable iff (!rstn)
		clk_en && pwr_r == PWR_WAKE_HOLD && wake_low |=> pwr_r == PWR_WAKE_HOLD;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake hold left while pin low");

	property p_idle_hold;
		@(posedge clock) disable iff (!rstn)
		idle_r && aux_r[AUX_HOLD_BIT] && !service && !overflow |=> $stable(cnt_r);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("counter moved in held idle");

	property p_idle_counts;
		@(posedge clock) disable iff (!rstn)
		clk_en && idle_r && !aux_r[AUX_HOLD_BIT] && enabled_r && mach_cycle_stb && pwr_r == PWR_RUN && !key_wr
		|-> count_en;
	endproperty
	a_idle_counts: assert property (p_idle_counts) else $error("counter stopped in idle");

	property p_bad_key;
		@(posedge clock) disable iff (!rstn)
		clk_en && key_wr && pwdata[7:0] != KEY_FIRST |=> !key_armed_r;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("sequence not abandoned");

	// Clock enable low freezes the counting state
	property p_clk_en_freeze;
		@(posedge clock) disable iff (!rstn)
		!clk_en |=> $stable(cnt_r) && $stable(enabled_r) && $stable(pulse_cnt_r) && $stable(pwr_r);
	endproperty
	a_clk_en_freeze: assert property (p_clk_en_freeze) else $error("state moved with enable low");

endmodule

// file: dv/wdr_watchdog_tb_top.sv
`timescale 1ns/100ps
module wdr_watchdog_tb_top import wdr_pkg::*;;
	localparam int CEIL = 95000;
	logic              clock, rstn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, d;
	logic [3:0]        pstrb;
	logic              mach_cycle_stb, idle_enter, pdown_enter, irq_pending;
	logic [1:0]        ext_wake_en;
	logic              ext_wake_irq_zero_n, ext_wake_irq_one_n, rst_pin_o, rst_pin_oe;
	logic              device_reset, idle_active, osc_stopped, err, hit;
	int                bad_count, total_checks, cycles, n;

	// Reset pin wire with pull-down
	wire rst_pin_i = rst_pin_oe & rst_pin_o;

	wdr_watchdog DUT (
		.clock(clock), .rstn(rstn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mach_cycle_stb(mach_cycle_stb),
		.idle_enter(idle_enter), .pdown_enter(pdown_enter), .irq_pending(irq_pending),
		.ext_wake_en(ext_wake_en), .ext_wake_irq_zero_n(ext_wake_irq_zero_n),
		.ext_wake_irq_one_n(ext_wake_irq_one_n), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
		.rst_pin_oe(rst_pin_oe), .device_reset(device_reset), .idle_active(idle_active),
		.osc_stopped(osc_stopped)
	);

	// Clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: timeout", $time);
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		cmp32({31'h0, got}, {31'h0, exp});
	endtask

	// One APB transfer, held until pready at a rising edge
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Idle cycles, flagging any device reset
	task automatic quiet(input int k);
		hit = 1'b0;
		repeat (k) begin
			@(posedge clock);
			if (device_reset !== 1'b0) hit = 1'b1;
		end
		cmp1(hit, 1'b0);
	endtask

	// Edges until device reset is seen high at an edge, idle pulse on the way
	task automatic to_reset();
		n = 0;
		while (device_reset !== 1'b1 && n < 17000) begin
			@(posedge clock);
			n = n + 1;
			idle_enter <= (n == 5);
		end
	endtask

	task automatic key_pair();
		xfer(1'b1, KEY_ADDR, {24'h0, KEY_FIRST});
		xfer(1'b1, KEY_ADDR, {24'h0, KEY_SECOND});
	endtask

	initial begin
		{rstn, psel, penable, pwrite, idle_enter, pdown_enter, irq_pending} = '0;
		{bad_count, total_checks, cycles} = '0;
		{paddr, pwdata, ext_wake_en} = '0;
		{clk_en, mach_cycle_stb, ext_wake_irq_zero_n, ext_wake_irq_one_n} = '1;
		pstrb = 4'hf;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		// Reset state and access kinds
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[1], 1'b0);
		xfer(1'b0, AUX_ADDR, 32'h0);
		cmp32(d, 32'h0000_0000);
		xfer(1'b0, KEY_ADDR, 32'h0);
		cmp32(d, 32'h0000_0000);
		xfer(1'b0, 12'hffc, 32'h0);
		cmp1(err, 1'b1);
		// Broken key pair must not enable
		xfer(1'b1, KEY_ADDR, {24'h0, KEY_FIRST});
		xfer(1'b1, KEY_ADDR, 32'h0000_0055);
		xfer(1'b1, KEY_ADDR, {24'h0, KEY_SECOND});
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[1], 1'b0);
		// Enable, count through idle to overflow; reset shows one edge after the last count
		key_pair();
		to_reset();
		cmp32(n, 32'(CNT_MAX) + 32'd1);
		cmp1(rst_pin_o & rst_pin_oe, 1'b1);
		n = 0;
		while (device_reset === 1'b1 && n < 200) begin
			@(posedge clock);
			n = n + 1;
		end
		cmp32(n, 32'(RST_PULSE_CYC));
		cmp1(idle_active, 1'b0);
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[1], 1'b0);
		// Servicing restarts the count
		key_pair();
		quiet(10000);
		key_pair();
		quiet(10000);
		// Power-down freezes; only enabled pin wakes; counter left at 2
		key_pair();
		@(posedge clock);
		pdown_enter <= 1'b1;
		ext_wake_en <= 2'b01;
		@(posedge clock);
		pdown_enter <= 1'b0;
		quiet(8000);
		irq_pending <= 1'b1;
		ext_wake_irq_one_n <= 1'b0;
		quiet(10);
		cmp1(osc_stopped, 1'b1);
		irq_pending <= 1'b0;
		ext_wake_irq_one_n <= 1'b1;
		ext_wake_irq_zero_n <= 1'b0;
		quiet(9000);
		cmp1(osc_stopped, 1'b1);
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[5], 1'b1);
		cmp1(d[4], 1'b0);
		ext_wake_irq_zero_n <= 1'b1;
		quiet(3);
		cmp1(osc_stopped, 1'b0);
		// Count on to about 6000, then idle with hold bit set freezes it there
		quiet(6000);
		xfer(1'b1, AUX_ADDR, 32'h0000_0010);
		@(posedge clock);
		idle_enter <= 1'b1;
		@(posedge clock);
		idle_enter <= 1'b0;
		quiet(11000);
		irq_pending <= 1'b1;
		quiet(3);
		irq_pending <= 1'b0;
		cmp1(idle_active, 1'b0);
		xfer(1'b0, AUX_ADDR, 32'h0);
		cmp32(d, 32'h0000_0010);
		xfer(1'b1, AUX_ADDR, 32'h0000_0000);
		// Clock enable low freezes the count as well
		@(posedge clock);
		clk_en <= 1'b0;
		quiet(3000);
		clk_en <= 1'b1;
		// Count resumes from about 6018: 10366 edges to the reset
		to_reset();
		cmp1(n >= 10356 && n <= 10376, 1'b1);
		// Hardware reset in mid-run returns it to disabled
		repeat (120) @(posedge clock);
		key_pair();
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[1], 1'b1);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		xfer(1'b0, STAT_ADDR, 32'h0);
		cmp1(d[1], 1'b0);
		end_sim();
	end
endmodule
